//--- rtl/pmt_pkg.sv
// Purpose: shared constants for program memory table read block
// Assumes: one 20 MHz clock, instruction cycle of four clocks
// Notes: constants used by both ends and the memory store
package pmt_pkg;
  localparam int          PMT_ADDR_W      = 14;
  localparam int          PMT_DATA_W      = 16;
  localparam int          PMT_DEPTH       = 16384;
  localparam int          PMT_DADDR_W     = 12;
  localparam logic [13:0] PMT_RESET_VEC   = 14'h0000;
  localparam logic [5:0]  PMT_LAST_PAGE   = 6'h3F;
  localparam logic [7:0]  PMT_TABLE_HIGH_LATCH_RST    = 8'h00;
  localparam logic [3:0]  PMT_SECTOR0     = 4'h0;
  localparam int          PMT_CLK_PER_IC  = 4;
  localparam int          PMT_READ_IC     = 2;
  localparam int          PMT_READ_CLKS   = PMT_CLK_PER_IC * PMT_READ_IC;
  localparam logic [3:0]  PMT_READ_CNT    = 4'(PMT_READ_CLKS - 1);

  typedef enum logic [1:0] {
    PMT_OP_TABRD     = 2'h0,
    PMT_OP_LASTPAGE  = 2'h1,
    PMT_OP_EXT       = 2'h2,
    PMT_OP_EXT_LAST  = 2'h3
  } pmt_op_type;
endpackage : pmt_pkg

//--- rtl/pmt_if.sv
`timescale 1ns/1ps
// Purpose: link between execution core end and table read device end
// Assumes: single clock domain, pins resolved by testbench
// Notes: open-drain style enables are active low
interface pmt_if;
  import pmt_pkg::*;
  // table read request
  logic                   rd_req;
  pmt_op_type             rd_op;
  logic [7:0]             ptr_lo;
  logic [7:0]             ptr_hi;
  logic [PMT_DADDR_W-1:0] dest_addr;
  logic                   rd_busy;
  // table read answer
  logic                   rd_done;
  logic [7:0]             lo_byte;
  logic [PMT_DADDR_W-1:0] wr_addr;
  logic                   dm_we;
  logic                   sector_err;
  // latch access
  logic                   table_high_latch_we;
  logic [7:0]             table_high_latch_wdata;
  logic [7:0]             table_high_latch_rdata;
  // fetch start after reset
  logic [PMT_ADDR_W-1:0]  fetch_pc;
  logic                   fetch_valid;

  modport dev (
    input  rd_req, rd_op, ptr_lo, ptr_hi, dest_addr, table_high_latch_we, table_high_latch_wdata,
    output rd_busy, rd_done, lo_byte, wr_addr, dm_we, sector_err,
    output table_high_latch_rdata, fetch_pc, fetch_valid
  );
  modport core (
    output rd_req, rd_op, ptr_lo, ptr_hi, dest_addr, table_high_latch_we, table_high_latch_wdata,
    input  rd_busy, rd_done, lo_byte, wr_addr, dm_we, sector_err,
    input  table_high_latch_rdata, fetch_pc, fetch_valid
  );
endinterface : pmt_if

//--- rtl/pmt_store.sv
`timescale 1ns/1ps
// Purpose: program word array with registered read and load port
// Assumes: load port used only by the programming path
// Notes: one read per clock, data one clock after address
module pmt_store
  import pmt_pkg::*;
#(
  parameter int AW = PMT_ADDR_W,
  parameter int DW = PMT_DATA_W
) (
  // clock only
  input  wire logic          mclk,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data,
  // load port
  input  wire logic          ld_we,
  input  wire logic [AW-1:0] ld_addr,
  input  wire logic [DW-1:0] ld_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk) begin
    if (ld_we) begin
      mem[ld_addr] <= ld_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : pmt_store

//--- rtl/pmt_dev.sv
`timescale 1ns/1ps
// Purpose: table read device end with serial pin front
// Assumes: core keeps one request outstanding
// Notes: serial protocols not modelled, pins sampled, released in debug mode, else driven by the shared function
module pmt_dev
  import pmt_pkg::*;
(
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // core link
  pmt_if.dev                   lnk,
  // programming load path
  input  wire logic            ld_we,
  input  wire logic [13:0]     ld_addr,
  input  wire logic [15:0]     ld_data,
  // debug mode and shared pins
  input  wire logic            dbg_active,
  input  wire logic            dbg_serial_io_in,
  output logic                 dbg_serial_io_out,
  output logic                 dbg_serial_io_oe_n,
  input  wire logic            dbg_serial_clk,
  input  wire logic            gpio_shared_out,
  input  wire logic            gpio_shared_oe_n,
  output logic                 dbg_data_s,
  output logic                 dbg_clk_s,
  output logic                 shared_func_en
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } pmt_st_type;

  pmt_st_type       st_r, st_nxt;
  logic [3:0]       cnt_r, cnt_nxt;
  logic [13:0]      addr_r, addr_nxt;
  logic [11:0]      dst_r, dst_nxt;
  logic [7:0]       table_high_latch_r, table_high_latch_nxt;
  logic [7:0]       lo_r, lo_nxt;
  logic             err_r, err_nxt;
  logic [15:0]      word;
  logic [1:0]       dio_sy_r, dck_sy_r;
  logic [1:0]       dio_sy_nxt, dck_sy_nxt;
  logic             fv_r, fv_nxt;

  pmt_store u_store (
    .mclk    (mclk),
    .rd_addr (addr_r),
    .rd_data (word),
    .ld_we   (ld_we),
    .ld_addr (ld_addr),
    .ld_data (ld_data)
  );

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    addr_nxt = addr_r;
    dst_nxt  = dst_r;
    table_high_latch_nxt = table_high_latch_r;
    lo_nxt   = lo_r;
    err_nxt  = err_r;
    if (lnk.table_high_latch_we) begin
      table_high_latch_nxt = lnk.table_high_latch_wdata;
    end
    unique case (st_r)
      ST_IDLE: begin
        if (lnk.rd_req) begin
          addr_nxt = {lnk.ptr_hi[5:0], lnk.ptr_lo};
          if (lnk.rd_op == PMT_OP_LASTPAGE ||
              lnk.rd_op == PMT_OP_EXT_LAST) begin
            addr_nxt = {PMT_LAST_PAGE, lnk.ptr_lo};
          end
          dst_nxt = lnk.dest_addr;
          err_nxt = !lnk.rd_op[1] &&
                    (lnk.dest_addr[11:8] != PMT_SECTOR0);
          cnt_nxt = PMT_READ_CNT;
          st_nxt  = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_r == 4'h1) begin
          st_nxt = ST_DONE;
          lo_nxt = word[7:0];
          if (!err_r) begin
            table_high_latch_nxt = word[15:8];
          end
        end
        cnt_nxt = cnt_r - 4'h1;
      end
      ST_DONE: begin
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= ST_IDLE;
      cnt_r    <= 4'h0;
      addr_r   <= PMT_RESET_VEC;
      dst_r    <= 12'h000;
      table_high_latch_r   <= PMT_TABLE_HIGH_LATCH_RST;
      lo_r     <= 8'h00;
      err_r    <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      addr_r   <= addr_nxt;
      dst_r    <= dst_nxt;
      table_high_latch_r   <= table_high_latch_nxt;
      lo_r     <= lo_nxt;
      err_r    <= err_nxt;
    end
  end

  // pin synchronisers; only the second stage feeds logic
  always_comb begin
    fv_nxt     = 1'b1;
    dio_sy_nxt = {dio_sy_r[0], dbg_serial_io_in};
    dck_sy_nxt = {dck_sy_r[0], dbg_serial_clk};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fv_r     <= 1'b0;
      dio_sy_r <= 2'h0;
      dck_sy_r <= 2'h0;
    end else begin
      fv_r     <= fv_nxt;
      dio_sy_r <= dio_sy_nxt;
      dck_sy_r <= dck_sy_nxt;
    end
  end

  assign lnk.fetch_pc    = PMT_RESET_VEC;
  assign lnk.fetch_valid = fv_r;
  assign lnk.rd_busy     = (st_r != ST_IDLE);
  assign lnk.rd_done     = (st_r == ST_DONE);
  assign lnk.dm_we       = (st_r == ST_DONE) && !err_r;
  assign lnk.lo_byte     = lo_r;
  assign lnk.wr_addr     = dst_r;
  assign lnk.sector_err  = (st_r == ST_DONE) && err_r;
  assign lnk.table_high_latch_rdata  = table_high_latch_r;

  assign shared_func_en     = !dbg_active;
  assign dbg_serial_io_out  = dbg_active ? 1'b0 : gpio_shared_out;
  assign dbg_serial_io_oe_n = dbg_active ? 1'b1 : gpio_shared_oe_n;
  assign dbg_data_s = dio_sy_r[1];
  assign dbg_clk_s  = dck_sy_r[1];
endmodule : pmt_dev

//--- rtl/pmt_core.sv
`timescale 1ns/1ps
// Purpose: execution core end issuing table reads
// Assumes: user side gives one command at a time
// Notes: interrupts masked while any table read is in flight
module pmt_core
  import pmt_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // device link
  pmt_if.core              lnk,
  // user command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire pmt_op_type  cmd_op,
  input  wire logic [7:0]  cmd_ptr_lo,
  input  wire logic [7:0]  cmd_ptr_hi,
  input  wire logic [11:0] cmd_dest,
  input  wire logic        cmd_table_high_latch_we,
  input  wire logic [7:0]  cmd_table_high_latch_wdata,
  // user result
  output logic             res_valid,
  output logic [7:0]       res_lo,
  output logic [7:0]       res_hi,
  output logic             res_err,
  output logic             int_mask,
  // programming pins
  input  wire logic        prog_serial_io_in,
  output logic             prog_serial_io_out,
  output logic             prog_serial_io_oe_n,
  output logic             prog_serial_clk
);
  logic       pend_r, pend_nxt;
  logic       rv_r;
  logic [7:0] lo_r, hi_r;
  logic       er_r;
  logic [1:0] pio_sy_r;

  assign cmd_ready      = !pend_r && !lnk.rd_busy;
  assign lnk.rd_req     = cmd_valid && cmd_ready;
  assign lnk.rd_op      = cmd_op;
  assign lnk.ptr_lo     = cmd_ptr_lo;
  assign lnk.ptr_hi     = cmd_ptr_hi;
  assign lnk.dest_addr  = cmd_dest;
  assign lnk.table_high_latch_we    = cmd_table_high_latch_we;
  assign lnk.table_high_latch_wdata = cmd_table_high_latch_wdata;

  always_comb begin
    pend_nxt = pend_r;
    if (lnk.rd_req) begin
      pend_nxt = 1'b1;
    end else if (lnk.rd_done) begin
      pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r   <= 1'b0;
      rv_r     <= 1'b0;
      lo_r     <= 8'h00;
      hi_r     <= 8'h00;
      er_r     <= 1'b0;
      pio_sy_r <= 2'h0;
    end else begin
      pend_r   <= pend_nxt;
      rv_r     <= lnk.rd_done;
      er_r     <= lnk.sector_err;
      pio_sy_r <= {pio_sy_r[0], prog_serial_io_in};
      if (lnk.dm_we) begin
        lo_r <= lnk.lo_byte;
      end
      if (lnk.rd_done) begin
        hi_r <= lnk.table_high_latch_rdata;
      end
    end
  end

  assign res_valid = rv_r;
  assign res_lo    = lo_r;
  assign res_hi    = hi_r;
  assign res_err   = er_r;
  assign int_mask  = pend_r;
  // programmer holds clock low; data idle released
  assign prog_serial_clk     = 1'b0;
  assign prog_serial_io_out  = 1'b0;
  assign prog_serial_io_oe_n = 1'b1;
endmodule : pmt_core

//--- tb/pmt_chk.sv
// Purpose: link checker for table reads
// Assumes: one clock, async low reset
// Notes: read ends eight clocks after take
`timescale 1ns/1ps
module pmt_chk
  import pmt_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // link signals
  input wire logic        rd_req,
  input wire pmt_op_type  rd_op,
  input wire logic [11:0] dest_addr,
  input wire logic        rd_busy,
  input wire logic        rd_done,
  input wire logic        dm_we,
  input wire logic        sector_err,
  input wire logic [11:0] wr_addr,
  input wire logic        table_high_latch_we,
  input wire logic [7:0]  table_high_latch_wdata,
  input wire logic [7:0]  table_high_latch_rdata,
  input wire logic [13:0] fetch_pc
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire tk  = rd_req & !rd_busy;
  // short form aimed outside sector zero
  wire bad = !rd_op[1] & (dest_addr[11:8] != 4'h0);
  sequence s_wait; !rd_done [*7]; endsequence
  sequence s_end; rd_done ##1 !rd_busy; endsequence
  property p_time; tk |=> s_wait ##1 s_end; endproperty
  a_time: assert property (p_time)
    else $error("read length wrong");
  property p_busy; tk |=> rd_busy [*8]; endproperty
  a_busy: assert property (p_busy)
    else $error("busy dropped early");
  property p_once; rd_done |=> !rd_done; endproperty
  a_once: assert property (p_once)
    else $error("done too long");
  property p_ok;
    tk && !bad |-> ##8 dm_we && !sector_err
      && wr_addr == $past(dest_addr, 8);
  endproperty
  a_ok: assert property (p_ok)
    else $error("low byte write wrong");
  property p_bad;
    tk && bad |-> ##8 sector_err && !dm_we && $stable(table_high_latch_rdata);
  endproperty
  a_bad: assert property (p_bad)
    else $error("sector refusal wrong");
  property p_tw;
    table_high_latch_we |=> rd_done || table_high_latch_rdata == $past(table_high_latch_wdata);
  endproperty
  a_tw: assert property (p_tw)
    else $error("latch write lost");
  property p_keep; $changed(table_high_latch_rdata) |-> rd_done || $past(table_high_latch_we);
  endproperty
  a_keep: assert property (p_keep)
    else $error("latch changed alone");
  property p_pc; fetch_pc == PMT_RESET_VEC; endproperty
  a_pc: assert property (p_pc)
    else $error("fetch start wrong");
endmodule : pmt_chk

//--- tb/program_memory_table_read_test.sv
// Purpose: bench for core and device ends
// Assumes: 50 ns clock, queue scoreboard
// Notes: short form outside sector 0 checks error and unchanged result bytes
`timescale 1ns/1ps
module program_memory_table_read_test;
  import pmt_pkg::*;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
  miscompares++; $display("MISMATCH t=%0t %h %h", $time, a, e); end end
  logic mclk = 0, rst_n = 0, cmd_valid = 0, cmd_table_high_latch_we = 0;
  logic ld_we = 0, dbg_active = 0, cmd_ready, res_valid, res_err;
  logic int_mask, pio_out, pio_oe_n, pclk, dio_out, dio_oe_n;
  logic sfe, dds, dcs;
  logic gpo = 0, gpo_oe_n = 1, dck = 0;
  logic [15:0] last_w = 0;
  pmt_op_type cmd_op = PMT_OP_TABRD;
  logic [7:0] cmd_ptr_lo = 0, cmd_ptr_hi = 0, cmd_table_high_latch_wdata = 0;
  logic [7:0] res_lo, res_hi, lo, hi;
  logic [11:0] cmd_dest = 0, dst;
  logic [13:0] ld_addr = 0;
  logic [15:0] ld_data = 0;
  logic [15:0] mem [logic [13:0]];
  logic [16:0] exp_q [$], e;
  int miscompares = 0, tests_run = 0, seed;
  // released pins read back high
  wire dio = !dio_oe_n ? dio_out : 1'b1;
  wire pio = !pio_oe_n ? pio_out : 1'b1;
  pmt_if lnk ();
  pmt_dev u_pmt_dev (.mclk(mclk), .rst_n(rst_n), .lnk(lnk),
    .ld_we(ld_we), .ld_addr(ld_addr), .ld_data(ld_data),
    .dbg_active(dbg_active), .dbg_serial_io_in(dio),
    .dbg_serial_io_out(dio_out), .dbg_serial_io_oe_n(dio_oe_n),
    .dbg_serial_clk(dck), .gpio_shared_out(gpo),
    .gpio_shared_oe_n(gpo_oe_n), .dbg_data_s(dds), .dbg_clk_s(dcs),
    .shared_func_en(sfe));
  pmt_core u_pmt_core (.mclk(mclk), .rst_n(rst_n), .lnk(lnk),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_ptr_lo(cmd_ptr_lo), .cmd_ptr_hi(cmd_ptr_hi),
    .cmd_dest(cmd_dest), .cmd_table_high_latch_we(cmd_table_high_latch_we),
    .cmd_table_high_latch_wdata(cmd_table_high_latch_wdata), .res_valid(res_valid),
    .res_lo(res_lo), .res_hi(res_hi), .res_err(res_err),
    .int_mask(int_mask), .prog_serial_io_in(pio),
    .prog_serial_io_out(pio_out), .prog_serial_io_oe_n(pio_oe_n),
    .prog_serial_clk(pclk));
  pmt_chk u_chk (.mclk(mclk), .rst_n(rst_n), .rd_req(lnk.rd_req),
    .rd_op(lnk.rd_op), .dest_addr(lnk.dest_addr),
    .rd_busy(lnk.rd_busy), .rd_done(lnk.rd_done), .dm_we(lnk.dm_we),
    .sector_err(lnk.sector_err), .wr_addr(lnk.wr_addr),
    .table_high_latch_we(lnk.table_high_latch_we), .table_high_latch_wdata(lnk.table_high_latch_wdata),
    .table_high_latch_rdata(lnk.table_high_latch_rdata), .fetch_pc(lnk.fetch_pc));
  initial forever #25 mclk = ~mclk;
  task ld(input logic [13:0] a, input logic [15:0] d);
    mem[a] = d;
    @(posedge mclk);
    ld_we <= 1;
    ld_addr <= a;
    ld_data <= d;
    @(posedge mclk);
    ld_we <= 0;
  endtask : ld
  task rd(input pmt_op_type op);
    logic [15:0] w;
    logic        bad;
    w = mem[op[0] ? {6'h3F, lo} : {hi[5:0], lo}];
    bad = !op[1] && dst[11:8] != 4'h0;
    // refused read leaves both result bytes as they were
    if (bad) w = last_w;
    last_w = w;
    exp_q.push_back({bad, w});
    @(posedge mclk);
    cmd_valid <= 1;
    cmd_op <= op;
    cmd_ptr_lo <= lo;
    cmd_ptr_hi <= hi;
    cmd_dest <= dst;
    @(negedge mclk);
    while (cmd_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    cmd_valid <= 0;
    @(negedge mclk);
    `CHK(int_mask, 1'b1)
    // next loads must not touch the word still being fetched
    while (cmd_ready !== 1'b1) @(negedge mclk);
    `CHK(int_mask, 1'b0)
  endtask : rd
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // scoreboard: oldest note against each result
  always @(negedge mclk) if (res_valid === 1'b1) begin
    e = exp_q.pop_front();
    `CHK(res_err, e[16])
    `CHK(res_lo, e[7:0])
    `CHK(res_hi, e[15:8])
  end
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h0EB7;
    repeat (6) @(posedge mclk);
    rst_n <= 1;
    // release edge still sees reset; valid rises one edge later
    @(negedge mclk);
    `CHK(lnk.fetch_valid, 1'b0)
    @(negedge mclk);
    `CHK(lnk.fetch_valid, 1'b1)
    `CHK(pio_oe_n, 1'b1)
    `CHK(pclk, 1'b0)
    for (int k = 0; k < 16; k++) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      dst = 12'($random(seed));
      if (k < 8) dst[11:8] = 4'h0;
      // both pages differ so a wrong page shows
      ld({hi[5:0], lo}, 16'($random(seed)));
      ld({6'h3F, lo}, 16'($random(seed)));
      rd(pmt_op_type'(k % 4));
    end
    $display("table read test done");
    repeat (12) @(posedge mclk);
    `CHK(exp_q.size(), 0)
    cmd_table_high_latch_we <= 1;
    cmd_table_high_latch_wdata <= 8'hA5;
    @(posedge mclk);
    cmd_table_high_latch_we <= 0;
    @(negedge mclk);
    `CHK(lnk.table_high_latch_rdata, 8'hA5)
    // shared function drives the pin low until debug takes it
    @(posedge mclk);
    gpo_oe_n <= 0;
    dck <= 1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK(dio_oe_n, 1'b0)
    `CHK(dds, 1'b0)
    `CHK(dcs, 1'b1)
    @(posedge mclk);
    dbg_active <= 1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK(sfe, 1'b0)
    `CHK(dio_oe_n, 1'b1)
    `CHK(dds, 1'b1)
    @(posedge mclk);
    dbg_active <= 0;
    rst_n <= 0;
    @(negedge mclk);
    `CHK(lnk.table_high_latch_rdata, PMT_TABLE_HIGH_LATCH_RST)
    `CHK(sfe, 1'b1)
    `CHK(lnk.fetch_valid, 1'b0)
    $display("latch and pin test done");
    tally_and_finish();
  end
endmodule : program_memory_table_read_test
